// ==== csb0_pkg.sv ====
// Functional notes
// R1: bit 6 sets receive-activity idle level
// R2: bit 5 sets transmit-activity idle level
// R3: bit 4 sets i2c-activity idle level
// R4: bit 3 sets suspend output idle level
// R5: bit 2 sets configured output idle level
// R6: bits 1-0 decode settings protection level
// R7: reset loads flash byte into working copy
// R8: bit 7 enables serial number enumeration
package csb0_pkg;
  // field positions inside the settings byte
  localparam int SN_EN_BIT = 7;
  localparam int RX_IDLE_BIT = 6;
  localparam int TX_IDLE_BIT = 5;
  localparam int I2C_IDLE_BIT = 4;
  localparam int SUSP_IDLE_BIT = 3;
  localparam int CFG_IDLE_BIT = 2;
  localparam int PROT_HI_BIT = 1;
  // value held before the flash copy arrives; also the factory value
  localparam logic [7:0] BYTE0_RESET = 8'h7C;
  // protection level encodings
  localparam logic [1:0] PROT_OPEN = 2'h0;
  localparam logic [1:0] PROT_PASSWORD = 2'h1;
  localparam logic [1:0] PROT_LOCKED = 2'h2;
  localparam logic [1:0] PROT_RESERVED = 2'h3;

  typedef enum logic [1:0] {
    CSB0_UNPROTECTED,
    CSB0_PASSWORD,
    CSB0_LOCKED,
    CSB0_RSVD
  } csb0_prot_t;

  // raw activity events from the functional blocks, active high
  typedef struct packed {
    logic rx_act;
    logic tx_act;
    logic i2c_act;
    logic suspended;
    logic configured;
  } csb0_events_t;

  // indicator pins after polarity is applied
  typedef struct packed {
    logic rx_led;
    logic tx_led;
    logic i2c_led;
    logic usb_suspend_output;
    logic enumeration_done_output;
  } csb0_pins_t;
endpackage

// ==== csb0_prot_dec.sv ====
`timescale 1ns/1ps
// decodes the two-bit protection field into a protection kind and two write flags
module csb0_prot_dec
  import csb0_pkg::*;
(
  input wire logic [1:0] level,
  output csb0_prot_t kind,
  output logic write_allowed,
  output logic password_needed
);
  // R6: protection decode
  always_comb begin
    case (level)
      PROT_OPEN: kind = CSB0_UNPROTECTED;
      PROT_PASSWORD: kind = CSB0_PASSWORD;
      PROT_LOCKED: kind = CSB0_LOCKED;
      default: kind = CSB0_RSVD;
    endcase
  end
  // reserved is treated as locked: safest reading of an undefined code
  assign write_allowed = (level == PROT_OPEN);
  assign password_needed = (level == PROT_PASSWORD);
endmodule

// ==== csb0_top.sv ====
`timescale 1ns/1ps
// settings byte zero: working copy, polarity of five indicators, protection level
module csb0_top
  import csb0_pkg::*;
(
  // clock and asynchronous active-low reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // flash image of the byte, taken once after each reset
  input wire logic [7:0] flash_byte, // stored factory or user image
  input wire logic flash_valid, // level or pulse, only the first one counts
  // host command path, already decoded to a one-cycle write strobe
  input wire logic cmd_write, // one-cycle write request
  input wire logic [7:0] cmd_wdata, // new byte value
  input wire logic cmd_unlocked, // password already accepted upstream
  // raw activity levels from the functional blocks, same clock
  input wire csb0_pkg::csb0_events_t events,
  // polarity-corrected indicator pins
  output csb0_pkg::csb0_pins_t pins,
  // working copy and its decoded fields
  output logic [7:0] chip_config_byte0, // whole working copy
  output logic serial_number_enumeration_enable, // bit 7 of the copy
  output logic [1:0] settings_protection_level, // bits 1-0 of the copy
  output logic loaded, // flash copy has been taken
  output logic write_rejected // one-cycle pulse per refused write
);
  import csb0_pkg::*;

  // whole state of the block
  typedef struct packed {
    logic [7:0] cfg;
    logic loaded;
    logic rejected;
    csb0_pins_t pins;
  } csb0_state_t;

  csb0_state_t st; // registered state
  csb0_state_t next_st; // value for the next edge
  csb0_prot_t prot_kind; // decoded protection level
  logic wr_ok; // writes open without password
  logic pw_needed; // writes need the host unlock

  // protection decode of the current working copy
  csb0_prot_dec u_dec (
    .level(st.cfg[PROT_HI_BIT:0]),
    .kind(prot_kind),
    .write_allowed(wr_ok),
    .password_needed(pw_needed)
  );

  // drive pin: idle level when quiet, its inverse when active
  function automatic logic drive_pin(input logic idle_level, input logic active);
    drive_pin = active ? ~idle_level : idle_level;
  endfunction

  // next state
  always_comb begin
    next_st = st;
    // the refusal flag is a pulse, so it falls unless refused again
    next_st.rejected = 1'b0;
    // the flash copy wins over a write in the same cycle; before the copy
    // arrives a write would be overwritten anyway, so it is dropped quietly
    if (flash_valid && !st.loaded) begin
      // R7: load flash copy
      next_st.cfg = flash_byte;
      next_st.loaded = 1'b1;
    end else if (cmd_write && st.loaded) begin
      // password level needs host unlock; locked/reserved refuse all
      if (wr_ok || (pw_needed && cmd_unlocked)) begin
        next_st.cfg = cmd_wdata;
      end else begin
        next_st.rejected = 1'b1;
      end
    end
    // pins use the byte held now, not the one being written: this costs a
    // cycle of latency after a write but keeps the pins free of glitches
    // R1: rx idle level
    next_st.pins.rx_led = drive_pin(st.cfg[RX_IDLE_BIT], events.rx_act);
    // R2: tx idle level
    next_st.pins.tx_led = drive_pin(st.cfg[TX_IDLE_BIT], events.tx_act);
    // R3: i2c idle level
    next_st.pins.i2c_led = drive_pin(st.cfg[I2C_IDLE_BIT], events.i2c_act);
    // R4: suspend idle level
    next_st.pins.usb_suspend_output = drive_pin(st.cfg[SUSP_IDLE_BIT], events.suspended);
    // R5: configured idle level
    next_st.pins.enumeration_done_output = drive_pin(st.cfg[CFG_IDLE_BIT], events.configured);
  end

  // state register; pins start at the factory idle levels
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st.cfg <= BYTE0_RESET;
      st.loaded <= 1'b0;
      st.rejected <= 1'b0;
      // pins rest at the idle levels of the reset byte
      st.pins <= csb0_pins_t'(BYTE0_RESET[RX_IDLE_BIT:CFG_IDLE_BIT]);
    end else begin
      st <= next_st;
    end
  end

  assign pins = st.pins;
  assign chip_config_byte0 = st.cfg;
  // R8: serial number enable
  assign serial_number_enumeration_enable = st.cfg[SN_EN_BIT];
  assign settings_protection_level = st.cfg[PROT_HI_BIT:0];
  assign loaded = st.loaded;
  assign write_rejected = st.rejected;

  // pin checks look one cycle back; the first edge out of reset is skipped
  // because the pins there still show the reset idle levels
  // R1: rx pin follows polarity
  chk_rx_polarity: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |->
      pins.rx_led == ($past(st.cfg[RX_IDLE_BIT]) ^ $past(events.rx_act)))
    else $error("rx pin polarity wrong");
  // R2: tx pin follows polarity
  chk_tx_polarity: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |->
      pins.tx_led == ($past(st.cfg[TX_IDLE_BIT]) ^ $past(events.tx_act)))
    else $error("tx pin polarity wrong");
  // R2: tx pin leaves its idle level when active
  chk_tx_active: assert property (@(posedge ref_clk) disable iff (!rst_b)
    events.tx_act |=> pins.tx_led != $past(st.cfg[TX_IDLE_BIT]))
    else $error("tx pin not asserted");
  // R3: i2c pin follows polarity
  chk_i2c_polarity: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !events.i2c_act ##1 1 |-> pins.i2c_led == $past(st.cfg[I2C_IDLE_BIT]))
    else $error("i2c pin idle level wrong");
  // R3: i2c pin leaves its idle level when active
  chk_i2c_active: assert property (@(posedge ref_clk) disable iff (!rst_b)
    events.i2c_act |=> pins.i2c_led != $past(st.cfg[I2C_IDLE_BIT]))
    else $error("i2c pin not asserted");
  // R4: suspend pin inverts when asserted
  chk_susp_polarity: assert property (@(posedge ref_clk) disable iff (!rst_b)
    events.suspended |=> pins.usb_suspend_output != $past(st.cfg[SUSP_IDLE_BIT]))
    else $error("suspend pin level wrong");
  // R4: suspend pin rests at its idle level
  chk_susp_idle: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !events.suspended |=> pins.usb_suspend_output == $past(st.cfg[SUSP_IDLE_BIT]))
    else $error("suspend pin idle level wrong");
  // R5: configured pin polarity
  chk_cfg_polarity: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $past(rst_b) |-> pins.enumeration_done_output
      == ($past(st.cfg[CFG_IDLE_BIT]) ^ $past(events.configured)))
    else $error("configured pin polarity wrong");
  // R6: locked byte never changes by command
  chk_lock_holds: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.loaded && settings_protection_level == PROT_LOCKED) |=> $stable(st.cfg))
    else $error("locked settings changed");
  // R6: password level without unlock refuses and keeps the byte
  chk_pw_refuse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd_write && st.loaded && settings_protection_level == PROT_PASSWORD
      && !cmd_unlocked) |=> (write_rejected && $stable(chip_config_byte0)))
    else $error("password write not refused");
  // R6: reserved code behaves as locked
  chk_rsvd_locked: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd_write && st.loaded && prot_kind == CSB0_RSVD) |=> write_rejected)
    else $error("reserved level write not refused");
  // R6: open level takes the write
  chk_open_write: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd_write && st.loaded && settings_protection_level == PROT_OPEN)
      |=> (chip_config_byte0 == $past(cmd_wdata) && !write_rejected))
    else $error("open write not taken");
  // R6: a refusal pulse only ever follows a write request
  chk_reject_cause: assert property (@(posedge ref_clk) disable iff (!rst_b)
    write_rejected |-> $past(cmd_write))
    else $error("refusal without write");
  // R7: flash copy taken on first valid
  chk_flash_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (flash_valid && !st.loaded) |=> (loaded && chip_config_byte0 == $past(flash_byte)))
    else $error("flash copy not loaded");
  // R7: once loaded, only a write may change the copy
  chk_load_once: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st.loaded && !cmd_write) |=> $stable(chip_config_byte0))
    else $error("copy changed without write");
  // R7: before the copy arrives, writes are dropped quietly
  chk_unloaded_quiet: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (!st.loaded && !flash_valid) |=> ($stable(chip_config_byte0) && !write_rejected))
    else $error("copy changed before load");
  // R8: enable comes from the flash image at load
  chk_sn_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
    $rose(loaded) |-> serial_number_enumeration_enable == $past(flash_byte[SN_EN_BIT]))
    else $error("serial enable not loaded");
  // R8: enable mirrors bit 7
  chk_sn_enable: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (cmd_write && st.loaded && wr_ok) |=>
      serial_number_enumeration_enable == $past(cmd_wdata[SN_EN_BIT]))
    else $error("serial enable not updated");

  cov_load: cover property (@(posedge ref_clk) disable iff (!rst_b) flash_valid && !st.loaded);
  cov_write: cover property (@(posedge ref_clk) disable iff (!rst_b) cmd_write && wr_ok);
  cov_reject: cover property (@(posedge ref_clk) disable iff (!rst_b) write_rejected);
  // password write accepted after unlock
  cov_pw_write: cover property (@(posedge ref_clk) disable iff (!rst_b)
    cmd_write && st.loaded && pw_needed && cmd_unlocked);
  // permanently locked byte refusing a write
  cov_locked_reject: cover property (@(posedge ref_clk) disable iff (!rst_b)
    write_rejected && settings_protection_level == PROT_LOCKED);
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import csb0_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] flash_byte = 8'h00;
  logic flash_valid = 1'b0;
  logic cmd_write = 1'b0;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_unlocked = 1'b0;
  csb0_events_t events = '0;
  csb0_pins_t pins;
  logic [7:0] chip_config_byte0;
  logic serial_number_enumeration_enable;
  logic [1:0] settings_protection_level;
  logic loaded;
  logic write_rejected;
  logic [17:0] notes[$]; // expected outputs, oldest first
  logic [17:0] got;
  logic [17:0] exp;
  logic [7:0] m_byte; // model of the working copy
  logic m_ld; // model of the loaded flag
  int failures = 0;
  int total_checks = 0;
  // 100 ns period
  always #50 ref_clk = ~ref_clk;
  csb0_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .flash_byte(flash_byte),
    .flash_valid(flash_valid), .cmd_write(cmd_write), .cmd_wdata(cmd_wdata),
    .cmd_unlocked(cmd_unlocked), .events(events), .pins(pins),
    .chip_config_byte0(chip_config_byte0),
    .serial_number_enumeration_enable(serial_number_enumeration_enable),
    .settings_protection_level(settings_protection_level), .loaded(loaded),
    .write_rejected(write_rejected));
  // field order matches the monitor's packing below
  task note(input logic rej, input logic [4:0] p);
    notes.push_back({rej, m_ld, m_byte[7], m_byte[1:0], m_byte, p});
  endtask
  // inputs are cleared first so nothing is taken at release
  task do_reset;
    @(negedge ref_clk);
    rst_b = 1'b0;
    flash_valid = 1'b0;
    cmd_write = 1'b0;
    events = '0;
    m_byte = BYTE0_RESET;
    m_ld = 1'b0;
    repeat (15) @(negedge ref_clk);
    #1 note(1'b0, 5'h1F);
    @(negedge ref_clk);
    rst_b = 1'b1;
  endtask
  // one cycle of stimulus; pins use the byte held before this edge
  task step(input logic fv, input logic [7:0] fb, input logic w, input logic [7:0] d,
            input logic u);
    logic rej;
    logic [4:0] p;
    @(negedge ref_clk);
    flash_valid = fv;
    flash_byte = fb;
    cmd_write = w;
    cmd_wdata = d;
    cmd_unlocked = u;
    events = csb0_events_t'(5'($urandom));
    @(posedge ref_clk);
    p = m_byte[6:2] ^ events;
    rej = 1'b0;
    if (fv && !m_ld) begin
      m_byte = fb;
      m_ld = 1'b1;
    end else if (w && m_ld) begin
      // open writes, password needs unlock, rest refused
      if (m_byte[1:0] == PROT_OPEN || (m_byte[1:0] == PROT_PASSWORD && u)) begin
        m_byte = d;
      end else begin
        rej = 1'b1;
      end
    end
    #1 note(rej, p);
  endtask
  // monitor: settled outputs against the oldest note
  always @(negedge ref_clk) begin
    if (notes.size() > 0) begin
      got = {write_rejected, loaded, serial_number_enumeration_enable,
             settings_protection_level, chip_config_byte0, pins};
      exp = notes.pop_front();
      total_checks++;
      if (got !== exp) begin
        failures++;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  end
  task tally_and_finish;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    logic [7:0] r;
    void'($urandom(32'hdb1d47a0));
    do_reset;
    step(1'b0, 8'h00, 1'b1, 8'hA5, 1'b1);
    $display("test write before load done");
    // every protection code, each after a fresh reset
    for (int p = 0; p < 4; p++) begin
      r = 8'($urandom);
      do_reset;
      step(1'b1, {r[7:2], 2'(p)}, 1'b0, 8'h00, 1'b0);
      step(1'b1, ~r, 1'b0, 8'h00, 1'b0);
      step(1'b0, 8'h00, 1'b1, {~r[7:2], 2'h1}, 1'b0);
      step(1'b0, 8'h00, 1'b1, {r[7:2], 2'h0}, 1'b1);
      repeat (8) step(1'b0, 8'h00, 1'b1, 8'($urandom), 1'($urandom));
      step(1'b0, 8'h00, 1'b0, 8'h00, 1'b0);
      $display("test protection %0d done", p);
    end
    repeat (2) @(negedge ref_clk);
    tally_and_finish;
  end
endmodule
